// file: rtl/aub_user_mgr.sv
`timescale 1ns/1ns
// How it works
// - Zero mode sends only zero user bits, ignoring buffer and input
// - Block mode passes blocks through three cascaded stores, host sees middle
// - Only block mode merges host written data into output
// - Each host word carries one byte in bits 15:8, low byte unused, no per-subframe blocks
// - MSB is earliest bit; first byte is earliest byte
// - Information unit is eight bits starting with a one
// - Up to eight zeros join units; nine or more end message
// - Q bits of received units collect into a readable register
// - A full message is buffered before transmission starts
// - Only unit payloads enter the FIFO; fillers are dropped
// - Output filler length equals shortest input filler seen
// - Long zero runs cause no writes, letting output drain
// - Empty FIFO sends zeros until a whole message arrives
// - Overwrite of unsent data resets whole FIFO synchronously
// - Overwrite raises a maskable interrupt pulse
module aub_user_mgr
    import aub_pkg::*;
#(
    parameter int DEPTH = FIFO_DEPTH
) (
    input wire logic I_REF_CLK,
    input wire logic I_RST,
    input wire logic [1:0] I_MODE,
    input wire logic I_OVW_IRQ_EN,
    input wire logic I_IN_BIT_VLD,
    input wire logic I_IN_BIT,
    input wire logic I_IN_BLK_START,
    input wire logic I_OUT_BIT_REQ,
    input wire logic I_OUT_BLK_START,
    input wire logic [4:0] I_HOST_ADDR,
    input wire logic I_HOST_WR,
    input wire logic [15:0] I_HOST_WDATA,
    output logic [15:0] O_HOST_RDATA,
    output logic O_OUT_BIT,
    output logic [Q_BITS-1:0] O_Q_CODE,
    output logic O_OVW_IRQ
);
    localparam int AW = $clog2(DEPTH);

    logic [1:0] mode_reg;
    logic clr;
    aub_rx_t rx_reg;
    logic [2:0] bit_cnt_reg;
    logic [IU_PAYLOAD-1:0] sh_reg;
    logic [3:0] zero_cnt_reg;
    logic [3:0] min_fill_reg;
    logic [7:0] msg_cnt_reg;
    logic [IU_PAYLOAD-1:0] mem [DEPTH];
    logic [AW-1:0] wr_reg;
    logic [AW-1:0] rd_reg;
    logic [AW:0] fill_reg;
    logic [AW:0] ready_reg;
    logic [AW:0] pend_reg;
    logic ovw;
    logic [3:0] tx_bit_reg;
    logic [3:0] tx_fill_reg;
    logic [IU_PAYLOAD-1:0] tx_sh_reg;
    logic tx_busy_reg;
    logic out_bit_reg;
    logic [Q_BITS-1:0] q_reg;
    logic irq_reg;
    logic [7:0] blk_rdata;
    logic blk_bit;
    logic in_vld;
    logic unit_done;
    logic msg_end;
    logic rd_en;

    // Mode latch; any change flushes consumer path
    always_ff @(posedge I_REF_CLK) begin
        if (I_RST) mode_reg <= MODE_ZERO;
        else mode_reg <= I_MODE;
    end
    assign clr = I_RST || (mode_reg != I_MODE) || ovw;

    assign in_vld = I_IN_BIT_VLD && (mode_reg == MODE_CONS);
    assign unit_done = in_vld && rx_reg == AUB_UNIT && bit_cnt_reg == 3'(IU_PAYLOAD - 1);
    assign msg_end = in_vld && rx_reg == AUB_FILL && !I_IN_BIT
        && zero_cnt_reg == 4'(GAP_LEN - 1);

    // Unit and message framing on the received bit stream
    always_ff @(posedge I_REF_CLK) begin
        if (clr) begin
            rx_reg <= AUB_IDLE;
            bit_cnt_reg <= 3'h0;
            zero_cnt_reg <= 4'h0;
            msg_cnt_reg <= 8'h00;
            min_fill_reg <= 4'(FILL_MAX);
        end else if (in_vld) begin
            case (rx_reg)
                AUB_IDLE, AUB_DONE: if (I_IN_BIT) begin
                    rx_reg <= AUB_UNIT;
                    bit_cnt_reg <= 3'h0;
                end
                AUB_UNIT: begin
                    sh_reg <= {sh_reg[IU_PAYLOAD-2:0], I_IN_BIT};
                    bit_cnt_reg <= bit_cnt_reg + 3'h1;
                    if (unit_done) begin
                        rx_reg <= AUB_FILL;
                        zero_cnt_reg <= 4'h0;
                        msg_cnt_reg <= msg_cnt_reg + 8'h01;
                    end
                end
                AUB_FILL: if (I_IN_BIT) begin
                    rx_reg <= AUB_UNIT;
                    bit_cnt_reg <= 3'h0;
                    if (zero_cnt_reg < min_fill_reg) min_fill_reg <= zero_cnt_reg;
                end else if (msg_end) begin
                    rx_reg <= AUB_DONE;
                    msg_cnt_reg <= 8'h00;
                end else begin
                    zero_cnt_reg <= zero_cnt_reg + 4'h1;
                end
                default: rx_reg <= AUB_IDLE;
            endcase
        end
    end

    // Q bit collector, first payload bit after start
    always_ff @(posedge I_REF_CLK) begin
        if (I_RST) q_reg <= '0;
        else if (in_vld && rx_reg == AUB_UNIT && bit_cnt_reg == 3'h0)
            q_reg <= {q_reg[Q_BITS-2:0], I_IN_BIT};
    end

    // FIFO write of unit payloads only; overwrite when full
    assign ovw = unit_done && fill_reg == (AW+1)'(DEPTH);
    always_ff @(posedge I_REF_CLK) begin
        if (clr) begin
            wr_reg <= '0;
        end else if (unit_done) begin
            mem[wr_reg] <= {sh_reg[IU_PAYLOAD-2:0], I_IN_BIT};
            wr_reg <= wr_reg + 1'b1;
        end else if (msg_end && msg_cnt_reg < 8'(MSG_MIN)) begin
            wr_reg <= wr_reg - pend_reg[AW-1:0];
        end
    end

    // Occupancy and count of units released as whole messages
    always_ff @(posedge I_REF_CLK) begin
        if (clr) begin
            fill_reg <= '0;
            pend_reg <= '0;
            ready_reg <= '0;
        end else begin
            if (msg_end) begin
                if (msg_cnt_reg >= 8'(MSG_MIN)) begin
                    ready_reg <= ready_reg + pend_reg - (AW+1)'(rd_en);
                    fill_reg <= fill_reg - (AW+1)'(rd_en);
                end else begin
                    // Short message is dropped from the FIFO
                    ready_reg <= ready_reg - (AW+1)'(rd_en);
                    fill_reg <= fill_reg - pend_reg - (AW+1)'(rd_en);
                end
                pend_reg <= '0;
            end else begin
                fill_reg <= fill_reg + (AW+1)'(unit_done) - (AW+1)'(rd_en);
                pend_reg <= pend_reg + (AW+1)'(unit_done);
                ready_reg <= ready_reg - (AW+1)'(rd_en);
            end
        end
    end

    // Transmit side: start bit, payload, then filler as long as the shortest input filler seen
    assign rd_en = I_OUT_BIT_REQ && !tx_busy_reg && ready_reg != '0;
    always_ff @(posedge I_REF_CLK) begin
        if (clr) begin
            rd_reg <= '0;
            tx_busy_reg <= 1'b0;
            tx_bit_reg <= 4'h0;
            tx_fill_reg <= 4'h0;
            tx_sh_reg <= '0;
        end else if (I_OUT_BIT_REQ) begin
            if (rd_en) begin
                tx_sh_reg <= mem[rd_reg];
                rd_reg <= rd_reg + 1'b1;
                tx_busy_reg <= 1'b1;
                tx_bit_reg <= 4'(IU_PAYLOAD);
                tx_fill_reg <= min_fill_reg;
            end else if (tx_bit_reg != 4'h0) begin
                tx_sh_reg <= {tx_sh_reg[IU_PAYLOAD-2:0], 1'b0};
                tx_bit_reg <= tx_bit_reg - 4'h1;
                if (tx_bit_reg == 4'h1 && tx_fill_reg == 4'h0) tx_busy_reg <= 1'b0;
            end else if (tx_fill_reg != 4'h0) begin
                // Free on the last filler bit so no extra zero is sent
                tx_fill_reg <= tx_fill_reg - 4'h1;
                if (tx_fill_reg == 4'h1) tx_busy_reg <= 1'b0;
            end else begin
                tx_busy_reg <= 1'b0;
            end
        end
    end

    // Output bit select per mode
    always_ff @(posedge I_REF_CLK) begin
        if (I_RST) begin
            out_bit_reg <= 1'b0;
        end else if (I_OUT_BIT_REQ) begin
            case (mode_reg)
                MODE_BLOCK: out_bit_reg <= blk_bit;
                MODE_CONS: out_bit_reg <= rd_en ? 1'b1
                    : (tx_bit_reg != 4'h0) && tx_sh_reg[IU_PAYLOAD-1];
                default: out_bit_reg <= 1'b0;
            endcase
        end
    end

    // Overwrite interrupt pulse
    always_ff @(posedge I_REF_CLK) begin
        if (I_RST) irq_reg <= 1'b0;
        else irq_reg <= ovw && I_OVW_IRQ_EN;
    end

    // Host word carries one byte in bits 15:8; low byte ignored on write, reads as zero
    aub_blkbuf u_blk (
        .i_clk(I_REF_CLK),
        .i_rst(I_RST),
        .i_in_bit_vld(I_IN_BIT_VLD),
        .i_in_bit(I_IN_BIT),
        .i_in_blk_start(I_IN_BLK_START),
        .i_out_bit_req(I_OUT_BIT_REQ),
        .i_out_blk_start(I_OUT_BLK_START),
        .i_host_addr(I_HOST_ADDR),
        .i_host_wr(I_HOST_WR && mode_reg == MODE_BLOCK),
        .i_host_wdata(I_HOST_WDATA[15:8]),
        .o_host_rdata(blk_rdata),
        .o_out_bit(blk_bit)
    );

    always_ff @(posedge I_REF_CLK) begin
        if (I_RST) O_HOST_RDATA <= 16'h0000;
        else O_HOST_RDATA <= {blk_rdata, 8'h00};
    end

    assign O_OUT_BIT = out_bit_reg;
    assign O_Q_CODE = q_reg;
    assign O_OVW_IRQ = irq_reg;

    chk_zero_mode_out: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
        mode_reg == MODE_ZERO && I_OUT_BIT_REQ |=> !O_OUT_BIT)
        else $error("zero mode sent a one");
    chk_ovw_clears_fifo: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
        ovw |=> fill_reg == '0 && ready_reg == '0)
        else $error("fifo not reset after overwrite");
    chk_ovw_irq_pulse: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
        ovw && I_OVW_IRQ_EN |=> O_OVW_IRQ)
        else $error("overwrite interrupt missing");
    chk_read_needs_msg: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
        rd_en |-> ready_reg != '0 && fill_reg != '0)
        else $error("read without whole message");
    chk_empty_sends_zero: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
        mode_reg == MODE_CONS && I_OUT_BIT_REQ && ready_reg == '0 && !tx_busy_reg
        |=> !O_OUT_BIT)
        else $error("empty fifo sent a one");
    chk_mode_change_clr: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
        mode_reg != I_MODE |=> fill_reg == '0 && rx_reg == AUB_IDLE)
        else $error("mode change left state");
    chk_fill_bounded: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
        fill_reg <= (AW+1)'(DEPTH) && ready_reg <= fill_reg)
        else $error("fifo count out of range");
    chk_zero_no_write: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
        in_vld && !I_IN_BIT && rx_reg != AUB_UNIT && !msg_end && !clr
        |=> $stable(wr_reg))
        else $error("filler written to fifo");
    cov_msg_end: cover property (@(posedge I_REF_CLK) msg_end && msg_cnt_reg >= 8'(MSG_MIN));
    cov_ovw: cover property (@(posedge I_REF_CLK) ovw);
    cov_tx_start: cover property (@(posedge I_REF_CLK) rd_en);
endmodule

// file: rtl/aub_pkg.sv
package aub_pkg;
    // User data mode field encodings
    localparam logic [1:0] MODE_ZERO = 2'h0;
    localparam logic [1:0] MODE_BLOCK = 2'h1;
    localparam logic [1:0] MODE_RSVD = 2'h2;
    localparam logic [1:0] MODE_CONS = 2'h3;
    // Information unit geometry
    localparam int IU_BITS = 8;
    localparam int IU_PAYLOAD = 7;
    localparam int Q_POS = 6;
    // Filler: up to eight zeros inside a message, nine or more is a gap
    localparam int FILL_MAX = 8;
    localparam int GAP_LEN = 9;
    localparam int MSG_MIN = 3;
    localparam int MSG_MAX = 129;
    // Block buffering: 192 frames of user bits as 24 bytes
    localparam int BLK_BYTES = 24;
    localparam int FIFO_DEPTH = 256;
    localparam int Q_BITS = 96;
    // Message assembly states, Gray coded along the usual path
    typedef enum logic [1:0] {
        AUB_IDLE = 2'b00,
        AUB_UNIT = 2'b01,
        AUB_FILL = 2'b11,
        AUB_DONE = 2'b10
    } aub_rx_t;
endpackage

// file: rtl/aub_blkbuf.sv
`timescale 1ns/1ns
// Three cascaded block stores; middle one faces the host byte port
module aub_blkbuf
    import aub_pkg::*;
#(
    parameter int NBYTES = BLK_BYTES
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_in_bit_vld,
    input wire logic i_in_bit,
    input wire logic i_in_blk_start,
    input wire logic i_out_bit_req,
    input wire logic i_out_blk_start,
    input wire logic [4:0] i_host_addr,
    input wire logic i_host_wr,
    input wire logic [7:0] i_host_wdata,
    output logic [7:0] o_host_rdata,
    output logic o_out_bit
);
    logic [7:0] in_mem [NBYTES];
    logic [7:0] mid_mem [NBYTES];
    logic [7:0] out_mem [NBYTES];
    logic [7:0] in_ptr_reg;
    logic [7:0] out_ptr_reg;
    logic [7:0] in_idx;

    // Block start bit always lands at bit 0 of the new block
    assign in_idx = i_in_blk_start ? 8'h00 : in_ptr_reg;

    // Receive store, MSB of each byte is earliest bit
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            in_ptr_reg <= 8'h00;
        end else if (i_in_bit_vld) begin
            in_mem[in_idx[7:3]][3'h7 - in_idx[2:0]] <= i_in_bit;
            in_ptr_reg <= i_in_blk_start ? 8'h01 : in_ptr_reg + 8'h01;
        end
    end

    // Middle store loads whole blocks, host writes win per byte
    always_ff @(posedge i_clk) begin
        for (int i = 0; i < NBYTES; i++) begin
            if (i_host_wr && i_host_addr == 5'(i)) begin
                mid_mem[i] <= i_host_wdata;
            end else if (i_in_bit_vld && i_in_blk_start) begin
                mid_mem[i] <= in_mem[i];
            end
        end
    end

    // Transmit store loads from middle at output block start
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            out_ptr_reg <= 8'h00;
        end else if (i_out_bit_req) begin
            if (i_out_blk_start) begin
                for (int i = 0; i < NBYTES; i++) out_mem[i] <= mid_mem[i];
                out_ptr_reg <= 8'h01;
            end else begin
                out_ptr_reg <= out_ptr_reg + 8'h01;
            end
        end
    end

    // Bit for this request; the parent registers it, so no extra lag
    assign o_out_bit = i_out_blk_start ? mid_mem[0][7]
        : out_mem[out_ptr_reg[7:3]][3'h7 - out_ptr_reg[2:0]];
    assign o_host_rdata = mid_mem[i_host_addr];
endmodule

// file: verification/aub_far_end.sv
`timescale 1ns/1ns
// Receiver and transmitter framing model on the far side of the user bit path
module aub_far_end (
    input wire logic i_clk,
    input wire logic i_out_bit,
    output logic o_in_bit_vld,
    output logic o_in_bit,
    output logic o_in_blk_start,
    output logic o_out_bit_req,
    output logic o_out_blk_start
);
    logic [255:0] got;
    // Idle levels at time zero
    initial begin
        o_in_bit_vld = 1'h0;
        o_in_bit = 1'h1;
        o_in_blk_start = 1'h0;
        o_out_bit_req = 1'h0;
        o_out_blk_start = 1'h0;
        got = '0;
    end
    // Received bits back to back, earliest first; idle line shows the inverse
    task automatic send(input logic [255:0] bits, input int n, input logic blk = 1'h0);
        for (int i = n - 1; i >= 0; i--) begin
            @(posedge i_clk);
            o_in_bit_vld <= 1'h1;
            o_in_bit <= bits[i];
            o_in_blk_start <= blk && (i == n - 1);
        end
        @(posedge i_clk);
        o_in_bit_vld <= 1'h0;
        o_in_blk_start <= 1'h0;
        o_in_bit <= ~bits[0];
    endtask
    // Transmitter takes one bit per request; newest bit lands in got[0]
    task automatic pull(input int n, input logic blk = 1'h0);
        got = '0;
        for (int i = 0; i < n; i++) begin
            @(posedge i_clk);
            o_out_bit_req <= 1'h1;
            o_out_blk_start <= blk && (i == 0);
            @(posedge i_clk);
            o_out_bit_req <= 1'h0;
            o_out_blk_start <= 1'h0;
            @(posedge i_clk);
            got = {got[254:0], i_out_bit};
        end
    endtask
endmodule

// file: verification/aes3_user_bit_manager_test.sv
`timescale 1ns/1ns
module aes3_user_bit_manager_test;
    import aub_pkg::*;
    localparam logic [7:0] u_a = 8'hc1;
    localparam logic [7:0] u_b = 8'h92;
    localparam logic [7:0] u_c = 8'hff;
    logic ref_clk = 1'h0;
    logic rst = 1'h1;
    logic [1:0] mode = MODE_ZERO;
    logic irq_en = 1'h0;
    logic hwr = 1'h0;
    logic [4:0] haddr = 5'h00;
    logic [15:0] hwdata = 16'h0000;
    logic in_vld, in_bit, in_blk, req, oblk, out_bit, ovw_irq;
    logic [15:0] hrdata;
    logic [Q_BITS-1:0] q_code;
    int err_count = 0;
    int n_checks = 0;
    int irq_cnt = 0;
    // 20 MHz reference clock
    always #25 ref_clk = ~ref_clk;
    // Count overwrite pulses seen
    always @(posedge ref_clk) if (ovw_irq === 1'h1) irq_cnt++;
    aub_user_mgr #(.DEPTH(8)) uut (
        .I_REF_CLK(ref_clk), .I_RST(rst), .I_MODE(mode), .I_OVW_IRQ_EN(irq_en),
        .I_IN_BIT_VLD(in_vld), .I_IN_BIT(in_bit), .I_IN_BLK_START(in_blk),
        .I_OUT_BIT_REQ(req), .I_OUT_BLK_START(oblk), .I_HOST_ADDR(haddr),
        .I_HOST_WR(hwr), .I_HOST_WDATA(hwdata), .O_HOST_RDATA(hrdata),
        .O_OUT_BIT(out_bit), .O_Q_CODE(q_code), .O_OVW_IRQ(ovw_irq)
    );
    aub_far_end far (
        .i_clk(ref_clk), .i_out_bit(out_bit), .o_in_bit_vld(in_vld), .o_in_bit(in_bit),
        .o_in_blk_start(in_blk), .o_out_bit_req(req), .o_out_blk_start(oblk)
    );
    task automatic check(input logic [255:0] seen, input logic [255:0] want);
        n_checks++;
        if (seen !== want) begin
            err_count++;
            $display("unexpected at %0t: seen %0h expected %0h", $time, seen, want);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic restart();
        @(posedge ref_clk);
        rst <= 1'h1;
        repeat (5) @(posedge ref_clk);
        rst <= 1'h0;
        @(posedge ref_clk);
    endtask
    task automatic host_wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        haddr <= a;
        hwdata <= d;
        hwr <= 1'h1;
        @(posedge ref_clk);
        hwr <= 1'h0;
    endtask
    task automatic host_rd(input logic [4:0] a, input logic [15:0] w);
        @(posedge ref_clk);
        haddr <= a;
        repeat (2) @(posedge ref_clk);
        check(hrdata, w);
    endtask
    // One received stream, then a fixed number of transmitted bits compared
    task automatic cons_case(input logic [255:0] s, input int n, input int p,
                             input logic [255:0] w);
        restart();
        mode <= MODE_CONS;
        far.send(s, n);
        repeat (4) @(posedge ref_clk);
        far.pull(p);
        check(far.got, w);
        $display("consumer case done");
    endtask
    task automatic test_fifo_order();
        restart();
        mode <= MODE_CONS;
        far.send({u_a, 2'h0, u_b, 2'h0}, 20);
        far.pull(4);
        check(far.got, 256'h0);
        far.send({u_c, 12'h000}, 20);
        repeat (4) @(posedge ref_clk);
        check(q_code[2:0], 3'h5);
        far.pull(30);
        check(far.got, {u_a, 2'h0, u_b, 2'h0, u_c, 2'h0});
        $display("fifo order test done");
    endtask
    task automatic test_zero_and_clear();
        cons_case({u_a, 1'h0, u_b, 1'h0, u_c, 12'h000}, 38, 0, 256'h0);
        mode <= MODE_ZERO;
        repeat (3) @(posedge ref_clk);
        far.pull(20);
        check(far.got, 256'h0);
        mode <= MODE_CONS;
        repeat (3) @(posedge ref_clk);
        far.pull(20);
        check(far.got, 256'h0);
        $display("zero mode and clear test done");
    endtask
    task automatic test_block_host();
        restart();
        mode <= MODE_BLOCK;
        host_wr(5'h00, 16'ha55a);
        host_wr(5'h17, 16'h3cff);
        host_rd(5'h00, 16'ha500);
        host_rd(5'h17, 16'h3c00);
        mode <= MODE_CONS;
        host_wr(5'h00, 16'h1111);
        mode <= MODE_BLOCK;
        host_rd(5'h00, 16'ha500);
        far.send(256'h5ac3, 16, 1'h1);
        far.send(256'h1, 1, 1'h1);
        host_rd(5'h00, 16'h5a00);
        far.pull(16, 1'h1);
        check(far.got, 256'h5ac3);
        $display("block host test done");
    endtask
    task automatic test_overwrite();
        logic [255:0] s;
        s = '0;
        for (int e = 1; e >= 0; e--) begin
            restart();
            irq_cnt = 0;
            irq_en <= e[0];
            mode <= MODE_CONS;
            for (int k = 0; k < 10; k++) s = {s[246:0], u_b, 1'h0};
            far.send(s, 90);
            far.send(256'h0, 12);
            repeat (4) @(posedge ref_clk);
            check(irq_cnt != 0, e[0]);
            far.pull(20);
            check(far.got, 256'h0);
        end
        $display("overwrite test done");
    endtask
    // Main sequence
    initial begin
        restart();
        test_fifo_order();
        cons_case({u_a, 8'h00, u_b, 1'h0, u_c, 9'h000}, 42, 27,
                  {u_a, 1'h0, u_b, 1'h0, u_c, 1'h0});
        cons_case({u_a, 2'h0, u_b, 12'h000}, 30, 16, 256'h0);
        test_zero_and_clear();
        test_block_host();
        test_overwrite();
        print_verdict();
    end
    // Watchdog against a hang
    initial begin
        repeat (60000) @(posedge ref_clk);
        err_count++;
        print_verdict();
    end
endmodule
